/* File: rtl/fan_tach_monitor_control.sv */
// Fan tach monitor core: pulse counter, limits, status, interrupt.
// Assumes a 200 MHz clk; the 100 kHz reference is derived inside.
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fan_tach_consts.svh"
module fan_tach_monitor_control (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fanPulseInput,
   output logic fanPinInEn,
   output logic tachIrq,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);
   localparam logic [11:0] REF_LAST = 12'(`REF_CYC - 1);
   localparam logic [15:0] CNT_TOP = `CNT_MAX;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [3:0] edgesNeeded(input logic [1:0] sel);
      case (sel)
         2'h0: edgesNeeded = 4'h2;
         2'h1: edgesNeeded = 4'h3;
         2'h2: edgesNeeded = 4'h5;
         default: edgesNeeded = 4'h9;
      endcase
   endfunction

   function automatic logic [31:0] mergeBytes(
      input logic [31:0] oldVal,
      input logic [31:0] newVal,
      input logic [3:0] strb
   );
      logic [31:0] res;
      res = oldVal;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = newVal[8*i +: 8];
         end
      end
      mergeBytes = res;
   endfunction

   // Returns {hit, data}; reads have no side effects
   function automatic logic [32:0] regValue(
      input fan_tach_pkg::main_st_t st,
      input logic [7:0] a,
      input logic pin
   );
      logic [31:0] d;
      logic hit;
      d = 32'h0;
      hit = 1'b1;
      case (a)
         `OFS_CTRL: begin
            d[31:16] = st.countField;
            d[`B_TGL_EN] = st.toggleIrqEn;
            d[`B_RDY_EN] = st.readyIrqEn;
            d[`B_EDGE +: 2] = st.edgeSel;
            d[`B_MODE] = st.countMode;
            d[`B_FILT] = st.filterOn;
            d[`B_RUN] = st.runOn;
            d[`B_LIM_EN] = st.limitIrqEn;
         end
         `OFS_STAT: begin
            d[`S_RDY] = st.readyFlag;
            d[`S_TGL] = st.toggleFlag;
            d[`S_PIN] = pin;
            d[`S_LIM] = st.limitFlag;
         end
         `OFS_HIGH: begin
            d[15:0] = st.highLimit;
         end
         `OFS_LOW: begin
            d[15:0] = st.lowLimit;
         end
         `OFS_MASK: begin
            d[3:0] = st.irqMask;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      regValue = {hit, d};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Submodules

   tach_bus_if rb();

   logic pinLevel;
   logic pinRise;
   logic pinFall;

   tach_axil_slave axil (
      .clk(clk),
      .rst_n(rst_n),
      .awvalid(awvalid),
      .awready(awready),
      .awaddr(awaddr),
      .wvalid(wvalid),
      .wready(wready),
      .wdata(wdata),
      .wstrb(wstrb),
      .bvalid(bvalid),
      .bready(bready),
      .bresp(bresp),
      .arvalid(arvalid),
      .arready(arready),
      .araddr(araddr),
      .rvalid(rvalid),
      .rready(rready),
      .rdata(rdata),
      .rresp(rresp),
      .rb(rb.bus)
   );

   fan_tach_pkg::main_st_t s;
   fan_tach_pkg::main_st_t next_s;

   tach_input_cond cond (
      .clk(clk),
      .rst_n(rst_n),
      .pinRaw(fanPulseInput),
      .run(s.runOn),
      .filterOn(s.filterOn),
      .level(pinLevel),
      .rise(pinRise),
      .fall(pinFall)
   );

   ////////////////////////////////////////////////////////////////////////
   // Core logic

   logic latchNow;
   logic [15:0] latchVal;
   logic edgeAny;
   logic intervalDone;
   logic [31:0] wrMerged;
   logic [3:0] clrBits;
   logic [32:0] wrLook;
   logic [32:0] rdLook;

   always_comb begin
      next_s = s;
      latchNow = 1'b0;
      latchVal = s.counter;
      edgeAny = pinRise || pinFall;
      intervalDone = edgeAny && (s.edgeCnt + 4'h1 >= edgesNeeded(s.edgeSel));
      wrLook = regValue(s, rb.wrAddr, pinLevel);
      rdLook = regValue(s, rb.rdAddr, pinLevel);
      wrMerged = mergeBytes(wrLook[31:0], rb.wrData, rb.wrStrb);
      clrBits = rb.wrData[3:0] & {4{rb.wrStrb[0]}};
      rb.wrOk = wrLook[32];
      rb.rdOk = rdLook[32];
      rb.rdData = rdLook[31:0];

      // Software writes first, so hardware sets below win over clears
      if (rb.wrEn) begin
         case (rb.wrAddr)
            `OFS_CTRL: begin
               next_s.toggleIrqEn = wrMerged[`B_TGL_EN];
               next_s.readyIrqEn = wrMerged[`B_RDY_EN];
               next_s.edgeSel = wrMerged[`B_EDGE +: 2];
               next_s.countMode = wrMerged[`B_MODE];
               next_s.filterOn = wrMerged[`B_FILT];
               next_s.runOn = wrMerged[`B_RUN];
               next_s.limitIrqEn = wrMerged[`B_LIM_EN];
            end
            `OFS_STAT: begin
               if (clrBits[`S_LIM]) begin
                  next_s.limitFlag = 1'b0;
               end
               if (clrBits[`S_TGL]) begin
                  next_s.toggleFlag = 1'b0;
               end
               if (clrBits[`S_RDY]) begin
                  next_s.readyFlag = 1'b0;
               end
            end
            `OFS_HIGH: begin
               next_s.highLimit = wrMerged[15:0];
            end
            `OFS_LOW: begin
               next_s.lowLimit = wrMerged[15:0];
            end
            `OFS_MASK: begin
               next_s.irqMask = wrMerged[3:0];
            end
            default: begin
            end
         endcase
      end

      // Idle freezes the counters in place; only refTick is cleared
      next_s.refTick = 1'b0;
      if (s.runOn) begin
         if (s.refDiv == REF_LAST) begin
            next_s.refDiv = 12'h0;
            next_s.refTick = 1'b1;
         end else begin
            next_s.refDiv = s.refDiv + 12'h1;
         end
         if (edgeAny) begin
            next_s.toggleFlag = 1'b1;
         end
         if (s.countMode) begin
            if (intervalDone) begin
               // Closing edge also opens the next interval
               latchNow = 1'b1;
               latchVal = s.counter;
               next_s.counter = 16'h0;
               next_s.edgeCnt = 4'h1;
            end else begin
               if (edgeAny) begin
                  next_s.edgeCnt = s.edgeCnt + 4'h1;
               end
               if (s.refTick) begin
                  if (s.counter + 16'h1 == CNT_TOP) begin
                     latchNow = 1'b1;
                     latchVal = CNT_TOP;
                     next_s.counter = 16'h0;
                     next_s.edgeCnt = 4'h0;
                  end else begin
                     next_s.counter = s.counter + 16'h1;
                  end
               end
            end
            if (latchNow) begin
               next_s.readyFlag = 1'b1;
            end
         end else if (pinRise) begin
            // Free running; firmware works with deltas of readings
            latchNow = 1'b1;
            latchVal = s.counter + 16'h1;
            next_s.counter = latchVal;
         end
         if (latchNow) begin
            next_s.countField = latchVal;
            if (latchVal > s.highLimit || latchVal < s.lowLimit) begin
               next_s.limitFlag = 1'b1;
            end
         end
      end

      next_s.irq = |({next_s.readyFlag && next_s.readyIrqEn,
         next_s.toggleFlag && next_s.toggleIrqEn,
         1'b0,
         next_s.limitFlag && next_s.limitIrqEn} & next_s.irqMask);
      next_s.pinInEn = next_s.runOn;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '{highLimit: `RST_HIGH, lowLimit: `RST_LOW,
            irqMask: `RST_MASK, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign fanPinInEn = s.pinInEn;
   assign tachIrq = s.irq;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   AST_REF_ADVANCE: assert property (@(posedge clk) disable iff (!rst_n)
      s.runOn && s.countMode && s.refTick && !edgeAny
      && s.counter < 16'hfffe
      |=> s.counter == $past(s.counter) + 16'h1)
      else $error("reference tick did not advance counter");

   AST_INTERVAL_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
      s.runOn && s.countMode && intervalDone
      |=> s.counter == 16'h0 && s.countField == $past(s.counter)
      && s.readyFlag)
      else $error("interval end did not latch and zero counter");

   AST_EDGE_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
      s.runOn && !s.countMode && pinRise
      |=> s.counter == $past(s.counter) + 16'h1
      && s.countField == s.counter)
      else $error("fan rise did not advance counter");

   AST_EDGE_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
      s.runOn && !s.countMode && pinRise && s.counter == CNT_TOP
      |=> s.counter == 16'h0)
      else $error("counter did not wrap to zero");

   AST_IDLE_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
      !s.runOn |=> $stable(s.counter) && $stable(s.countField)
      && $stable(s.edgeCnt) && $stable(s.refDiv))
      else $error("idle block changed counters");

   AST_PIN_HIGHZ: assert property (@(posedge clk) disable iff (!rst_n)
      !s.runOn ##1 !s.runOn |-> !fanPinInEn)
      else $error("fan pin driven while idle");

   AST_FLAG_PENDING: assert property (@(posedge clk) disable iff (!rst_n)
      !s.runOn && s.limitFlag && !rb.wrEn |=> s.limitFlag)
      else $error("pending flag lost while idle");

   AST_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_n)
      s.runOn && s.countMode && s.refTick && !intervalDone
      && s.counter == 16'hfffe
      |=> s.countField == CNT_TOP && s.counter == 16'h0)
      else $error("all ones not latched");

   AST_LIMIT_SET: assert property (@(posedge clk) disable iff (!rst_n)
      latchNow && latchVal > s.highLimit
      |=> s.limitFlag
      ##1 (tachIrq || !(s.limitFlag && s.limitIrqEn
      && s.irqMask[0])))
      else $error("limit violation not flagged");

   AST_IRQ_BLOCKED: assert property (@(posedge clk) disable iff (!rst_n)
      !s.limitIrqEn && !s.toggleFlag && !s.readyFlag
      && !next_s.toggleFlag && !next_s.readyFlag
      && !next_s.limitIrqEn |=> !tachIrq)
      else $error("limit flag raised interrupt while disabled");
endmodule

/* File: rtl/fan_tach_consts.svh */
// Fan tach monitor: register offsets, field positions, resets, timing.
// Included by the design modules and the bench; holds definitions only.
`ifndef FAN_TACH_CONSTS_SVH
`define FAN_TACH_CONSTS_SVH
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_HIGH 8'h08
`define OFS_LOW 8'h0c
`define OFS_MASK 8'h10
`define B_LIM_EN 0
`define B_RUN 1
`define B_FILT 8
`define B_MODE 10
`define B_EDGE 11
`define B_RDY_EN 14
`define B_TGL_EN 15
`define S_LIM 0
`define S_PIN 1
`define S_TGL 2
`define S_RDY 3
`define RST_HIGH 16'hffff
`define RST_LOW 16'h0000
`define RST_MASK 4'hf
`define CLK_NS 5
`define REF_NS 10000
`define REF_CYC (`REF_NS / `CLK_NS)
`define FILT_CYC (2 * `REF_CYC)
`define CNT_MAX 16'hffff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: rtl/fan_tach_pkg.sv */
// Fan tach monitor: state types shared by the design modules.
// Widths here match the constants header.
package fan_tach_pkg;
   typedef struct packed {
      logic countMode;
      logic filterOn;
      logic runOn;
      logic limitIrqEn;
      logic readyIrqEn;
      logic toggleIrqEn;
      logic [1:0] edgeSel;
      logic [15:0] countField;
      logic [15:0] counter;
      logic [3:0] edgeCnt;
      logic limitFlag;
      logic toggleFlag;
      logic readyFlag;
      logic [15:0] highLimit;
      logic [15:0] lowLimit;
      logic [3:0] irqMask;
      logic [11:0] refDiv;
      logic refTick;
      logic irq;
      logic pinInEn;
   } main_st_t;
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic level;
      logic [12:0] stable;
      logic rise;
      logic fall;
   } cond_st_t;
   typedef struct packed {
      logic awready;
      logic awDone;
      logic [7:0] awAddr;
      logic wready;
      logic wDone;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_st_t;
endpackage

/* File: rtl/tach_bus_if.sv */
// Register access path from the bus slave to the monitor core.
// Single clock; write is a one-cycle strobe, read is combinational.
`timescale 1ns/1ps
interface tach_bus_if;
   logic wrEn;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic wrOk;
   logic [7:0] rdAddr;
   logic [31:0] rdData;
   logic rdOk;
   modport bus(output wrEn, wrAddr, wrData, wrStrb, rdAddr,
      input wrOk, rdData, rdOk);
   modport regs(input wrEn, wrAddr, wrData, wrStrb, rdAddr,
      output wrOk, rdData, rdOk);
endinterface

/* File: rtl/tach_input_cond.sv */
// Fan pulse input conditioning: synchroniser, glitch filter, edges.
// Pin is asynchronous to clk; run freezes the filter while idle.
`timescale 1ns/1ps
`include "fan_tach_consts.svh"
module tach_input_cond (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pinRaw,
   input wire logic run,
   input wire logic filterOn,
   output logic level,
   output logic rise,
   output logic fall
);
   localparam logic [12:0] FILT_LAST = 13'(`FILT_CYC - 1);
   fan_tach_pkg::cond_st_t s;
   fan_tach_pkg::cond_st_t next_s;

   always_comb begin
      next_s = s;
      next_s.sync1 = pinRaw;
      next_s.sync2 = s.sync1;
      next_s.rise = 1'b0;
      next_s.fall = 1'b0;
      if (run) begin
         if (s.sync2 == s.level) begin
            next_s.stable = 13'h0;
         end else if (!filterOn || s.stable == FILT_LAST) begin
            // With the filter on, narrow pulses never reach the edge logic
            next_s.level = s.sync2;
            next_s.stable = 13'h0;
            next_s.rise = s.sync2;
            next_s.fall = !s.sync2;
         end else begin
            next_s.stable = s.stable + 13'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign level = s.level;
   assign rise = s.rise;
   assign fall = s.fall;

   AST_FILTER_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      run && filterOn && s.sync2 != s.level && s.stable < FILT_LAST
      |=> !rise && !fall)
      else $error("filter passed a short pulse");
   AST_SYNC_PATH: assert property (@(posedge clk) disable iff (!rst_n)
      rise |-> $past(s.sync2, 1) && $past(run, 1))
      else $error("edge not from second sync stage");
endmodule

/* File: rtl/tach_axil_slave.sv */
// AXI4-Lite slave front end for the fan tach monitor registers.
// AW and W taken in either order; one write and one read in flight.
`timescale 1ns/1ps
`include "fan_tach_consts.svh"
module tach_axil_slave (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   tach_bus_if.bus rb
);
   fan_tach_pkg::axil_st_t s;
   fan_tach_pkg::axil_st_t next_s;

   always_comb begin
      next_s = s;
      rb.wrEn = 1'b0;
      rb.wrAddr = {s.awAddr[7:2], 2'h0};
      rb.wrData = s.wData;
      rb.wrStrb = s.wStrb;
      rb.rdAddr = {araddr[7:2], 2'h0};
      if (awvalid && s.awready) begin
         next_s.awDone = 1'b1;
         next_s.awAddr = awaddr;
         next_s.awready = 1'b0;
      end
      if (wvalid && s.wready) begin
         next_s.wDone = 1'b1;
         next_s.wData = wdata;
         next_s.wStrb = wstrb;
         next_s.wready = 1'b0;
      end
      if (s.awDone && s.wDone && !s.bvalid) begin
         rb.wrEn = 1'b1;
         next_s.bvalid = 1'b1;
         next_s.bresp = rb.wrOk ? `RESP_OKAY : `RESP_SLVERR;
         next_s.awDone = 1'b0;
         next_s.wDone = 1'b0;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
         next_s.awready = 1'b1;
         next_s.wready = 1'b1;
      end
      if (arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = rb.rdData;
         next_s.rresp = rb.rdOk ? `RESP_OKAY : `RESP_SLVERR;
         next_s.arready = 1'b0;
      end
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
         next_s.arready = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
endmodule

/* File: test/fan_tach_model.sv */
// Fan tach output model: a train of square pulses on request.
// Assumes the bench strobes start for one clk; pin idles low.
`timescale 1ns/1ps
module fan_tach_model (
   input wire logic clk,
   input wire logic start,
   input wire logic [15:0] width,
   input wire logic [7:0] pulses,
   output logic pin,
   output logic busy
);
   logic [15:0] t;
   logic [7:0] left;
   // Stopped fan holds its last level, as a real rotor does
   initial begin
      pin = 0;
      left = 0;
      t = 0;
   end
   always @(posedge clk) begin
      if (start) begin
         left <= pulses;
         t <= 16'h0000;
         pin <= 1'b0;
      end else if (left != 0) begin
         if (t == width - 1) begin
            t <= 16'h0000;
            pin <= ~pin;
            if (pin) begin
               left <= left - 1;
            end
         end else begin
            t <= t + 1;
         end
      end
   end
   assign busy = (left != 0);
endmodule

/* File: test/fan_tach_monitor_control_tb.sv */
// Bench for the fan tach monitor: AXI4-Lite master, fan model.
// Assumes 200 MHz clk and the register map of the constants header.
`timescale 1ns/1ps
`include "fan_tach_consts.svh"
module fan_tach_monitor_control_tb;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, pinEn, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic fanPin, fanStart, fanBusy;
   logic [15:0] fanWidth;
   logic [7:0] fanPulses;
   int fails, num_checks, cyc;
   ////////////////////////////////////////
   fan_tach_monitor_control i_fan_tach_monitor_control (.clk(clk),
      .rst_n(rst_n), .fanPulseInput(fanPin), .fanPinInEn(pinEn),
      .tachIrq(irq), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
   fan_tach_model i_fan_tach_model (.clk(clk), .start(fanStart),
      .width(fanWidth), .pulses(fanPulses), .pin(fanPin),
      .busy(fanBusy));
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   // Ceiling just above the ~93k cycles the scenarios need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 99000) begin
         fails++;
         summarize;
      end
   end
   ////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string m);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic axW(input logic [7:0] a, input logic [31:0] v);
      logic aw, w;
      aw = 0;
      w = 0;
      @(posedge clk);
      awvalid <= 1;
      awaddr <= a;
      wvalid <= 1;
      wdata <= v;
      wstrb <= 4'hf;
      bready <= 1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (!aw && awready) begin
            aw = 1;
            awvalid <= 0;
         end
         if (!w && wready) begin
            w = 1;
            wvalid <= 0;
         end
      end
      while (!bvalid) @(posedge clk);
      r = bresp;
      bready <= 0;
   endtask
   task automatic axR(input logic [7:0] a);
      @(posedge clk);
      arvalid <= 1;
      araddr <= a;
      rready <= 1;
      @(posedge clk);
      while (!arready) @(posedge clk);
      arvalid <= 0;
      @(posedge clk);
      while (!rvalid) @(posedge clk);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask
   task automatic fan(input logic [15:0] w, input logic [7:0] n);
      @(posedge clk);
      fanWidth <= w;
      fanPulses <= n;
      fanStart <= 1;
      @(posedge clk);
      fanStart <= 0;
      @(posedge clk);
   endtask
   task automatic fanWait(input int extra);
      while (fanBusy) @(posedge clk);
      repeat (extra) @(posedge clk);
   endtask
   task automatic cnt(input logic [15:0] e, input string m);
      axR(`OFS_CTRL);
      chk({16'h0000, d[31:16]}, {16'h0000, e}, m);
   endtask
   task automatic waitRdy;
      do axR(`OFS_STAT); while (d[`S_RDY] !== 1'b1);
   endtask
   ////////////////////////////////////////
   task automatic testReset;
      chk(pinEn, 0, "pin enabled after reset");
      cnt(16'h0000, "count after reset");
      chk(d, 32'h0, "control after reset");
      axR(`OFS_STAT);
      chk(d, 32'h0, "status after reset");
      axR(`OFS_HIGH);
      chk(d, 32'h0000ffff, "high limit after reset");
      axR(`OFS_LOW);
      chk(d, 32'h0, "low limit after reset");
      axR(`OFS_MASK);
      chk(d, 32'h0000000f, "mask after reset");
      axR(8'h20);
      chk(r, `RESP_SLVERR, "unmapped read");
      axW(8'h20, 32'h1);
      chk(r, `RESP_SLVERR, "unmapped write");
   endtask
   task automatic testEdge;
      axW(`OFS_CTRL, 32'hffff0002);
      chk(pinEn, 1, "pin not enabled");
      fan(16'h0064, 8'h03);
      fanWait(20);
      cnt(16'h0003, "rise count");
      cnt(16'h0003, "count moved by read");
   endtask
   task automatic testIdle;
      axW(`OFS_CTRL, 32'h0);
      chk(pinEn, 0, "pin driven while idle");
      fan(16'h0064, 8'h02);
      fanWait(20);
      axR(`OFS_STAT);
      chk(d[`S_TGL], 1, "toggle flag lost");
      axW(`OFS_CTRL, 32'h2);
      cnt(16'h0003, "counted while idle");
      fan(16'h0064, 8'h01);
      fanWait(20);
      cnt(16'h0004, "count not resumed");
   endtask
   task automatic testFilter;
      axW(`OFS_CTRL, 32'h102);
      fan(16'd1000, 8'h01);
      fanWait(20);
      cnt(16'h0004, "glitch counted");
      fan(16'd4500, 8'h01);
      fanWait(4100);
      cnt(16'h0005, "wide pulse lost");
   endtask
   task automatic testLimit;
      axW(`OFS_STAT, 32'hf);
      axW(`OFS_HIGH, 32'h0);
      axW(`OFS_CTRL, 32'h2);
      fan(16'h0064, 8'h01);
      fanWait(20);
      axR(`OFS_STAT);
      chk(d[`S_LIM], 1, "limit flag not set");
      chk(irq, 0, "irq with limit enable off");
      axW(`OFS_CTRL, 32'h3);
      repeat (2) @(posedge clk);
      chk(irq, 1, "irq with limit enable on");
      axW(`OFS_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk(irq, 0, "masked irq");
      axW(`OFS_MASK, 32'hf);
      axW(`OFS_STAT, 32'h1);
      axR(`OFS_STAT);
      chk(d[`S_LIM], 0, "limit flag not cleared");
      chk(irq, 0, "irq after clear");
      axW(`OFS_CTRL, 32'h8003);
      repeat (2) @(posedge clk);
      chk(irq, 1, "toggle irq missing");
      axW(`OFS_HIGH, 32'hffff);
   endtask
   // Interval of n edges at 2000 clk per edge spans n-1 ticks
   task automatic testRef;
      int n;
      logic inRange;
      for (int s = 0; s < 4; s++) begin
         n = (s == 0) ? 2 : (s == 1) ? 3 : (s == 2) ? 5 : 9;
         axW(`OFS_CTRL, 32'h402 | (s << 11));
         axW(`OFS_STAT, 32'h8);
         fan(16'd2000, n[7:0]);
         waitRdy;
         axW(`OFS_STAT, 32'h8);
         waitRdy;
         axR(`OFS_CTRL);
         inRange = d[31:16] >= n - 2 && d[31:16] <= n;
         chk(inRange, 1, "ref count");
         fanWait(10);
      end
   endtask
   ////////////////////////////////////////
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, fanStart} = 0;
      {awaddr, araddr, wdata, wstrb, fanWidth, fanPulses} = 0;
      {fails, num_checks, cyc} = 0;
      rst_n = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1;
      testReset;
      testEdge;
      testIdle;
      testFilter;
      testLimit;
      testRef;
      summarize;
   end
endmodule
